// File: oesc_pkg.sv
// package: constants and types for the oscillator enable and sleep control block
package oesc_pkg;
  // ----------------------------------------
  // sleep modes
  // ----------------------------------------
  typedef enum logic [1:0] {OESC_ACTIVE, OESC_IDLE, OESC_STANDBY} oesc_sleep_t;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_RUN_ON_REQUEST = 1'b1;
  localparam logic RST_STANDBY_RUN = 1'b0;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_IRQ_FLAG = 1'b0;

  // ----------------------------------------
  // start-up timing
  // ----------------------------------------
  localparam int STARTUP_W = 4;
  localparam int SU_CNT_W = 24;
  // start-up code n gives 2^n ticks of the oscillator time base
  localparam int OSC_COUNT = 2;
  localparam int IDX_HF = 0;
  localparam int IDX_SLOW = 1;
endpackage

// File: oesc_osc_ctrl.sv
// module: run decision, start-up masking and ready flag for one oscillator
`timescale 1ns/1ps
module oesc_osc_ctrl
  import oesc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic run_on_request_i,
  input wire logic standby_run_enable_i,
  input wire logic always_in_sleep_i,
  input wire logic periph_request_i,
  input wire oesc_sleep_t sleep_mode_i,
  input wire logic tick_i,
  input wire logic [STARTUP_W-1:0] startup_i,
  output logic run_o,
  output logic ready_o,
  output logic ready_rise_o
);
  logic [SU_CNT_W-1:0] su_count;
  logic [SU_CNT_W-1:0] su_target;
  logic want_run;
  logic idle_run;
  logic stby_run;
  logic next_ready;

  assign idle_run = !run_on_request_i || periph_request_i;
  assign stby_run = standby_run_enable_i && idle_run;
  assign want_run = enable_i && (always_in_sleep_i
    || (sleep_mode_i == OESC_ACTIVE)
    || (sleep_mode_i == OESC_IDLE && idle_run)
    || (sleep_mode_i == OESC_STANDBY && stby_run));
  assign su_target = SU_CNT_W'(1) << startup_i;
  // ready only after the full count; a stop clears it so restart re-masks
  assign next_ready = want_run && (ready_o || (tick_i && su_count + 1'b1 >= su_target));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      su_count <= '0;
      run_o <= 1'b0;
      ready_o <= 1'b0;
      ready_rise_o <= 1'b0;
    end
    else
    begin
      run_o <= want_run;
      su_count <= !want_run ? '0 : (tick_i && !ready_o) ? su_count + 1'b1 : su_count;
      ready_o <= next_ready;
      ready_rise_o <= next_ready && !ready_o;
    end
  end
endmodule

// File: oesc_top.sv
// module: top of the oscillator enable and sleep control block
`timescale 1ns/1ps
module oesc_top
  import oesc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic por_n_i,
  input wire logic wr_i,
  input wire logic prot_i,
  input wire logic cpu_debug_halt_i,
  input wire logic debugger_access_i,
  input wire logic cold_plug_i,
  input wire logic brownout_high_rst_i,
  input wire logic brownout_core_rst_i,
  input wire logic [OSC_COUNT-1:0] enable_i,
  input wire logic [OSC_COUNT-1:0] run_on_request_i,
  input wire logic [OSC_COUNT-1:0] standby_run_enable_i,
  input wire logic [OSC_COUNT-1:0] crystal_select_i,
  input wire logic [STARTUP_W-1:0] hf_startup_i,
  input wire logic [STARTUP_W-1:0] slow_startup_i,
  input wire logic auto_amplitude_gain_i,
  input wire logic slow_output_enable_i,
  input wire logic [OSC_COUNT-1:0] irq_enable_set_i,
  input wire logic [OSC_COUNT-1:0] irq_enable_clr_i,
  input wire logic [OSC_COUNT-1:0] irq_flag_clr_i,
  input wire logic [OSC_COUNT-1:0] periph_request_i,
  input wire logic [1:0] sleep_mode_i,
  input wire logic tick_i,
  output logic [OSC_COUNT-1:0] osc_run_o,
  output logic [OSC_COUNT-1:0] osc_clk_gate_o,
  output logic [OSC_COUNT-1:0] power_clock_status_o,
  output logic [OSC_COUNT-1:0] irq_flag_o,
  output logic [OSC_COUNT-1:0] irq_enable_o,
  output logic irq_o,
  output logic wake_o,
  output logic osc_in_pin_own_o,
  output logic osc_out_pin_own_o,
  output logic slow_osc_in_pin_own_o,
  output logic slow_osc_out_pin_own_o,
  output logic auto_gain_active_o,
  output logic slow_clk_out_en_o,
  output logic ulp_slow_oscillator_run_o,
  output logic brownout_high_rst_o,
  output logic brownout_core_rst_o
);
  // ----------------------------------------
  // reset and input synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic [1:0] por_sync;
  logic rst_n;
  logic por_n;
  logic [1:0] tick_sync;
  logic [1:0] req_meta;
  logic [1:0] req_sync;
  logic [1:0] bo_meta;
  logic [1:0] bo_sync;
  logic tick_prev;
  logic tick_rise;

  assign rst_n = rst_sync[1];
  assign por_n = por_sync[1];

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  always_ff @(posedge sys_clk_i or negedge por_n_i)
  begin
    if (!por_n_i)
      por_sync <= 2'h0;
    else
      por_sync <= {por_sync[0], 1'b1};
  end

  // pins and oscillator time base come from other domains
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_sync <= 2'h0;
      req_meta <= 2'h0;
      req_sync <= 2'h0;
      bo_meta <= 2'h0;
      bo_sync <= 2'h0;
      tick_prev <= 1'b0;
    end
    else
    begin
      tick_sync <= {tick_sync[0], tick_i};
      req_meta <= periph_request_i;
      req_sync <= req_meta;
      bo_meta <= {brownout_high_rst_i, brownout_core_rst_i};
      bo_sync <= bo_meta;
      tick_prev <= tick_sync[1];
    end
  end

  assign tick_rise = tick_sync[1] && !tick_prev;

  // ----------------------------------------
  // write protection and control latching
  // ----------------------------------------
  logic wr_ok;
  oesc_sleep_t sleep_mode;
  logic [OSC_COUNT-1:0] en;
  logic [OSC_COUNT-1:0] run_on_request;
  logic [OSC_COUNT-1:0] stby;
  logic [OSC_COUNT-1:0] xtal;
  logic [STARTUP_W-1:0] hf_su;
  logic [STARTUP_W-1:0] slow_su;
  logic auto_amplitude_gain;
  logic slow_oe;
  logic [OSC_COUNT-1:0] ready;
  logic [OSC_COUNT-1:0] rise;
  logic [OSC_COUNT-1:0] run;
  logic [OSC_COUNT-1:0] osc_rst_n;

  assign wr_ok = wr_i && (!prot_i || cpu_debug_halt_i || debugger_access_i);
  assign sleep_mode = oesc_sleep_t'(sleep_mode_i);
  // slow oscillator only answers to power-on reset, as a crystal restart is slow
  assign osc_rst_n = {por_n, rst_n};

  // hf controls: reset by the system reset arst_n_i only, not by power-on reset alone
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en[IDX_HF] <= RST_ENABLE;
      run_on_request[IDX_HF] <= RST_RUN_ON_REQUEST;
      stby[IDX_HF] <= RST_STANDBY_RUN;
      xtal[IDX_HF] <= 1'b0;
      hf_su <= '0;
      auto_amplitude_gain <= 1'b0;
    end
    else if (wr_ok)
    begin
      en[IDX_HF] <= enable_i[IDX_HF];
      run_on_request[IDX_HF] <= run_on_request_i[IDX_HF];
      stby[IDX_HF] <= standby_run_enable_i[IDX_HF];
      xtal[IDX_HF] <= crystal_select_i[IDX_HF];
      hf_su <= hf_startup_i;
      auto_amplitude_gain <= auto_amplitude_gain_i;
    end
  end

  // slow controls: kept across all resets but power-on
  always_ff @(posedge sys_clk_i or negedge por_n)
  begin
    if (!por_n)
    begin
      en[IDX_SLOW] <= RST_ENABLE;
      run_on_request[IDX_SLOW] <= RST_RUN_ON_REQUEST;
      stby[IDX_SLOW] <= RST_STANDBY_RUN;
      xtal[IDX_SLOW] <= 1'b0;
      slow_su <= '0;
      slow_oe <= 1'b0;
    end
    else if (wr_ok)
    begin
      en[IDX_SLOW] <= enable_i[IDX_SLOW];
      run_on_request[IDX_SLOW] <= run_on_request_i[IDX_SLOW];
      stby[IDX_SLOW] <= standby_run_enable_i[IDX_SLOW];
      xtal[IDX_SLOW] <= crystal_select_i[IDX_SLOW];
      slow_su <= slow_startup_i;
      slow_oe <= slow_output_enable_i;
    end
  end

  // ----------------------------------------
  // oscillator controllers
  // ----------------------------------------
  // debug halt is not an input of the controllers, so nothing stops on it
  genvar gi;
  generate
    for (gi = 0; gi < OSC_COUNT; gi++)
    begin : g_osc
      oesc_osc_ctrl i_oesc_osc_ctrl (
        .clk_i(sys_clk_i),
        .rst_n_i(osc_rst_n[gi]),
        .enable_i(en[gi]),
        .run_on_request_i(run_on_request[gi]),
        .standby_run_enable_i(stby[gi]),
        .always_in_sleep_i(gi == IDX_SLOW),
        .periph_request_i(req_sync[gi]),
        .sleep_mode_i(sleep_mode),
        .tick_i(tick_rise),
        .startup_i(gi == IDX_HF ? hf_su : slow_su),
        .run_o(run[gi]),
        .ready_o(ready[gi]),
        .ready_rise_o(rise[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // interrupt flags and enables
  // ----------------------------------------
  logic [OSC_COUNT-1:0] next_flag;
  logic [OSC_COUNT-1:0] next_ien;
  logic [OSC_COUNT-1:0] ien_clr;

  // rising edge wins over a clear in the same cycle; clear is never protected
  assign next_flag = (irq_flag_o & ~irq_flag_clr_i) | rise;
  assign ien_clr = wr_ok ? irq_enable_clr_i : '0;
  assign next_ien = wr_ok ? ((irq_enable_o & ~ien_clr) | irq_enable_set_i) : irq_enable_o;

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_flag_o <= {OSC_COUNT{RST_IRQ_FLAG}};
      irq_enable_o <= {OSC_COUNT{RST_IRQ_EN}};
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end
    else
    begin
      irq_flag_o <= next_flag;
      irq_enable_o <= next_ien;
      irq_o <= |(next_flag & next_ien);
      wake_o <= (sleep_mode == OESC_STANDBY) && |(next_flag & next_ien);
    end
  end

  // ----------------------------------------
  // status, pins and outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_run_o <= '0;
      osc_clk_gate_o <= '0;
      power_clock_status_o <= '0;
      osc_in_pin_own_o <= 1'b0;
      osc_out_pin_own_o <= 1'b0;
      slow_osc_in_pin_own_o <= 1'b0;
      slow_osc_out_pin_own_o <= 1'b0;
      auto_gain_active_o <= 1'b0;
      slow_clk_out_en_o <= 1'b0;
      ulp_slow_oscillator_run_o <= 1'b0;
      brownout_high_rst_o <= 1'b0;
      brownout_core_rst_o <= 1'b0;
    end
    else
    begin
      osc_run_o <= run;
      osc_clk_gate_o <= ready;
      power_clock_status_o <= ready;
      osc_in_pin_own_o <= en[IDX_HF];
      osc_out_pin_own_o <= en[IDX_HF] && xtal[IDX_HF];
      slow_osc_in_pin_own_o <= en[IDX_SLOW];
      slow_osc_out_pin_own_o <= en[IDX_SLOW] && xtal[IDX_SLOW];
      auto_gain_active_o <= en[IDX_HF] && xtal[IDX_HF] && auto_amplitude_gain;
      slow_clk_out_en_o <= slow_oe && xtal[IDX_SLOW] && ready[IDX_SLOW];
      ulp_slow_oscillator_run_o <= 1'b1;
      // cold-plug lets a too-high brown-out level be corrected
      brownout_high_rst_o <= bo_sync[1] && !cold_plug_i;
      brownout_core_rst_o <= bo_sync[0] && !cold_plug_i;
    end
  end
endmodule

// File: oesc_properties.sv
// checker: port-level properties of the oscillator enable and sleep control block
`timescale 1ns/1ps
module oesc_checker
  import oesc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic por_n_i,
  input wire logic wr_i,
  input wire logic prot_i,
  input wire logic cpu_debug_halt_i,
  input wire logic debugger_access_i,
  input wire logic cold_plug_i,
  input wire logic [OSC_COUNT-1:0] enable_i,
  input wire logic [OSC_COUNT-1:0] irq_flag_clr_i,
  input wire logic [1:0] sleep_mode_i,
  input wire logic [OSC_COUNT-1:0] osc_run_o,
  input wire logic [OSC_COUNT-1:0] power_clock_status_o,
  input wire logic [OSC_COUNT-1:0] irq_flag_o,
  input wire logic [OSC_COUNT-1:0] irq_enable_o,
  input wire logic irq_o,
  input wire logic osc_in_pin_own_o,
  input wire logic osc_out_pin_own_o,
  input wire logic ulp_slow_oscillator_run_o,
  input wire logic brownout_high_rst_o,
  input wire logic brownout_core_rst_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // one cycle of slack on the answers, the run decision may sit behind a register
  wire logic wr_ok = wr_i && (!prot_i || cpu_debug_halt_i || debugger_access_i);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i || !por_n_i);
  property p_ulp; ulp_slow_oscillator_run_o |=> ulp_slow_oscillator_run_o; endproperty
  a_ulp: assert property (p_ulp) else $error("ulp oscillator stopped");
  property p_pin; osc_out_pin_own_o |-> osc_in_pin_own_o; endproperty
  a_pin: assert property (p_pin) else $error("output pin taken without input pin");
  property p_en; (wr_ok && enable_i[0] && sleep_mode_i == 2'h0) |-> ##3 (osc_run_o[0] && osc_in_pin_own_o); endproperty
  a_en: assert property (p_en) else $error("enabled oscillator not running");
  property p_dis; (wr_ok && !enable_i[0]) |-> ##3 !(osc_run_o[0] || osc_in_pin_own_o); endproperty
  a_dis: assert property (p_dis) else $error("disabled oscillator still running");
  property p_prot; (wr_i && !wr_ok) |=> $stable(irq_enable_o); endproperty
  a_prot: assert property (p_prot) else $error("protected write took effect");
  property p_clr; (irq_flag_clr_i[0] && power_clock_status_o[0]) |=> !irq_flag_o[0]; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_rdy; $rose(power_clock_status_o[0]) |-> irq_flag_o[0]; endproperty
  a_rdy: assert property (p_rdy) else $error("ready rise without flag");
  property p_irq; (|(irq_flag_o & irq_enable_o)) [*2] |-> irq_o; endproperty
  a_irq: assert property (p_irq) else $error("enabled flag without interrupt");
  property p_bo; cold_plug_i [*4] |-> !(brownout_high_rst_o || brownout_core_rst_o); endproperty
  a_bo: assert property (p_bo) else $error("brownout reset not masked");
endmodule
bind oesc_top oesc_checker i_oesc_checker (.*);

// File: oesc_top_bench.sv
// testbench: self-checking bench for the oscillator enable and sleep control block
`timescale 1ns/1ps
module oesc_top_bench import oesc_pkg::*;;
  logic sys_clk_i = '0, arst_n_i = '0, por_n_i = '0, wr_i = '0, prot_i = '0, tick_i = '0;
  logic cpu_debug_halt_i = '0, debugger_access_i = '0, cold_plug_i = '0;
  logic brownout_high_rst_i = '0, brownout_core_rst_i = '0;
  logic auto_amplitude_gain_i = '0, slow_output_enable_i = '0;
  logic [1:0] enable_i = '0, run_on_request_i = '0, standby_run_enable_i = '0;
  logic [1:0] crystal_select_i = '0, irq_enable_set_i = '0, irq_enable_clr_i = '0;
  logic [1:0] irq_flag_clr_i = '0, periph_request_i = '0, sleep_mode_i = '0;
  logic [3:0] hf_startup_i = '0, slow_startup_i = '0;
  logic [1:0] osc_run_o, osc_clk_gate_o, power_clock_status_o, irq_flag_o, irq_enable_o;
  logic irq_o, wake_o, osc_in_pin_own_o, osc_out_pin_own_o, slow_osc_in_pin_own_o;
  logic slow_osc_out_pin_own_o, auto_gain_active_o, slow_clk_out_en_o;
  logic ulp_slow_oscillator_run_o, brownout_high_rst_o, brownout_core_rst_o;
  localparam logic [18:0] RUN0 = 19'h20000, RUN1 = 19'h40000, RDY0 = 19'h08000, FLG0 = 19'h02000;
  localparam logic [18:0] IEN0 = 19'h00800, IEN1 = 19'h01000, IRQ = 19'h00400, WAKE = 19'h00200;
  localparam logic [18:0] PIN = 19'h00180, SPIN = 19'h00060, AGC = 19'h00010, SCK = 19'h00008;
  localparam logic [18:0] ULP = 19'h00004, BO = 19'h00003;
  wire logic [18:0] obs = {osc_run_o, power_clock_status_o, irq_flag_o, irq_enable_o, irq_o,
    wake_o, osc_in_pin_own_o, osc_out_pin_own_o, slow_osc_in_pin_own_o, slow_osc_out_pin_own_o,
    auto_gain_active_o, slow_clk_out_en_o, ulp_slow_oscillator_run_o, brownout_high_rst_o,
    brownout_core_rst_o};
  logic [37:0] q[$];
  logic probe = '0;
  int failures = 0;
  int checks_done = 0;

  oesc_top i_oesc_top (.*);

  // ----------------------------------------
  // clock, time base and result watcher
  // ----------------------------------------
  initial forever #5 sys_clk_i = ~sys_clk_i;
  // time base runs free, unrelated to the write timing
  always @(negedge sys_clk_i) tick_i <= ~tick_i;
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // outputs read at the edge before its own updates land
  always @(posedge sys_clk_i)
    if (probe)
    begin
      check(obs & q[0][37:19], q[0][18:0]);
      void'(q.pop_front());
    end
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic expect_out(input logic [18:0] m, input logic [18:0] v);
    q.push_back({m, v});
    probe = 1'b1;
    cyc(1);
    probe = 1'b0;
  endtask
  task automatic write();
    wr_i = 1'b1;
    cyc(1);
    wr_i = 1'b0;
  endtask
  task automatic wait_rdy(output int n);
    n = 0;
    while (power_clock_status_o[0] !== 1'b1)
    begin
      n++;
      if (n > 300)
      begin
        failures++;
        give_verdict();
      end
      cyc(1);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    int n;
    int su;
    logic e;
    void'($urandom(32'hB1E59D00));
    cyc(5);
    arst_n_i = 1'b1;
    por_n_i = 1'b1;
    cyc(3);
    expect_out(19'h7FFFF, ULP);
    $display("test reset done");
    su = 2 + $urandom_range(1, 0);
    hf_startup_i = su[3:0];
    slow_startup_i = 4'h1;
    {enable_i, crystal_select_i, irq_enable_set_i} = 6'h3D;
    {auto_amplitude_gain_i, slow_output_enable_i} = 2'h3;
    write();
    wait_rdy(n);
    check(19'(n >= (2 << su) - 2 && n <= (2 << su) + 8), 19'h1);
    cyc(1);
    expect_out(RUN0 | RUN1 | PIN | SPIN | AGC | SCK | IEN0 | RDY0 | FLG0 | IRQ, RUN0 | RUN1 | PIN | SPIN | AGC | SCK | IEN0 | RDY0 | FLG0 | IRQ);
    check(19'(osc_clk_gate_o), 19'h3);
    prot_i = 1'b1;
    irq_flag_clr_i = 2'h1;
    cyc(1);
    irq_flag_clr_i = 2'h0;
    cyc(1);
    expect_out(RDY0 | FLG0 | IRQ, RDY0);
    $display("test start-up done");
    for (int i = 0; i < 3; i++)
    begin
      cpu_debug_halt_i = (i == 1);
      debugger_access_i = (i == 2);
      enable_i = (i == 1) ? 2'h3 : 2'h2;
      irq_enable_set_i = (i == 2) ? 2'h0 : 2'h2;
      irq_enable_clr_i = (i == 2) ? 2'h1 : 2'h0;
      write();
      cyc(4);
      expect_out(RUN0 | PIN | RDY0 | IEN0 | IEN1, i == 0 ? RUN0 | PIN | RDY0 | IEN0 : i == 1 ? RUN0 | PIN | RDY0 | IEN0 | IEN1 : IEN1);
    end
    {debugger_access_i, cpu_debug_halt_i, irq_enable_clr_i} = 4'h4;
    $display("test protection done");
    for (int i = 0; i < 16; i++)
    begin
      sleep_mode_i = 2'h0;
      {run_on_request_i, standby_run_enable_i} = {1'($urandom), i[2], 1'($urandom), i[1]};
      crystal_select_i = 2'($urandom);
      auto_amplitude_gain_i = 1'($urandom);
      enable_i = 2'h3;
      write();
      // an already ready oscillator must still see three active cycles
      cyc(3);
      wait_rdy(n);
      periph_request_i = {1'($urandom), i[0]};
      sleep_mode_i = i[3] ? 2'h2 : 2'h1;
      cyc(6);
      e = (!i[2] || i[0]) && (!i[3] || i[1]);
      expect_out(RUN0 | RUN1 | SPIN | SCK | AGC | WAKE | ULP, (e ? RUN0 : 19'h0) | RUN1 | (crystal_select_i[1] ? SPIN | SCK : 19'h00040) | (crystal_select_i[0] && auto_amplitude_gain_i ? AGC : 19'h0) | (i[3] ? WAKE : 19'h0) | ULP);
    end
    $display("test sleep modes done");
    sleep_mode_i = 2'h0;
    enable_i = 2'h1;
    write();
    cyc(4);
    expect_out(RUN1 | SPIN | SCK | 19'h10000, 19'h0);
    enable_i = 2'h3;
    write();
    arst_n_i = 1'b0;
    cyc(2);
    arst_n_i = 1'b1;
    cyc(6);
    expect_out(RUN0 | RUN1, RUN1);
    {por_n_i, arst_n_i} = 2'h0;
    cyc(2);
    {por_n_i, arst_n_i} = 2'h3;
    cyc(6);
    expect_out(RUN1 | SPIN, 19'h0);
    $display("test resets done");
    {brownout_high_rst_i, brownout_core_rst_i, cold_plug_i} = 3'h7;
    cyc(6);
    expect_out(BO, 19'h0);
    cold_plug_i = 1'b0;
    cyc(6);
    expect_out(BO, BO);
    $display("test brownout done");
    give_verdict();
  end
endmodule
